// >>> core/psch_defs.svh
// Constants of the parameter store command handler.
// Assumes one 50 MHz clock; included by the package and the modules.
`ifndef PSCH_DEFS_SVH
`define PSCH_DEFS_SVH
`define PSCH_OP_STORE_AXIS    8'h07
`define PSCH_OP_RESTORE_AXIS  8'h08
`define PSCH_OP_WRITE_GLOBAL  8'h09
`define PSCH_OP_READ_GLOBAL   8'h0a
`define PSCH_OP_PERSIST_GLOB  8'h0b
`define PSCH_BANK_SETTINGS    8'h00
`define PSCH_BANK_USER        8'h02
`define PSCH_BANK_IRQ         8'h03
`define PSCH_ST_OK            8'h64
`define PSCH_ST_BAD_SUM       8'h01
`define PSCH_ST_BAD_CMD       8'h02
`define PSCH_ST_BAD_TYPE      8'h03
`define PSCH_ST_BAD_VALUE     8'h04
`define PSCH_FRAME_LAST       4'h8
`define PSCH_AXIS_FIRST       2'h0
`define PSCH_AXIS_LAST        2'h1
`define PSCH_ADDR_W           10
`define PSCH_AREA_AXIS        2'h0
`define PSCH_AREA_SET         2'h1
`define PSCH_AREA_USER        2'h2
`define PSCH_AREA_IRQ         2'h3
`endif

// >>> core/psch_mem.sv
// Working memory: 1024-word memory with registered read data.
// Assumes one clock; a read returns data one edge after the request.
`include "psch_defs.svh"
module psch_mem (
	input  wire logic                    clk_in,    // System clock
	input  wire logic                    we_in,     // Write strobe
	input  wire logic [`PSCH_ADDR_W-1:0] waddr_in,  // Write address
	input  wire logic [31:0]             wdata_in,  // Write data
	input  wire logic [`PSCH_ADDR_W-1:0] raddr_in,  // Read address
	output logic      [31:0]             rdata_out  // Registered read data
);
	logic [31:0] mem [0:(1<<`PSCH_ADDR_W)-1];
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule

// >>> core/psch_pkg.sv
// Types of the parameter store command handler.
// Assumes psch_defs.svh sits on the include path.
`include "psch_defs.svh"
package psch_pkg;
	typedef enum logic [7:0] {
		PSCH_IDLE  = 8'h01,
		PSCH_BOOT  = 8'h02,
		PSCH_BOOTW = 8'h04,
		PSCH_RECV  = 8'h08,
		PSCH_EXEC  = 8'h10,
		PSCH_NVW   = 8'h20,
		PSCH_NVR   = 8'h40,
		PSCH_REPLY = 8'h80
	} psch_state_e;
	typedef struct packed {
		logic [7:0]  target;
		logic [7:0]  instr;
		logic [7:0]  ptype;
		logic [7:0]  bank;
		logic [31:0] value;
	} psch_frame_s;
	typedef struct packed {
		logic [7:0]  status;
		logic [7:0]  instr;
		logic [31:0] value;
	} psch_reply_s;
	typedef struct packed {
		psch_state_e                state;
		logic [3:0]                 idx;
		logic [7:0]                 sum;
		psch_frame_s                frm;
		logic [`PSCH_ADDR_W-1:0]    boot_addr;
		logic [`PSCH_ADDR_W-1:0]    nv_addr;
		logic                       nv_we;
		logic                       nv_re;
		logic                       nv_pend;
		logic [31:0]                nv_wdata;
		logic                       busy;
		logic                       rsp_valid;
		psch_reply_s                rsp;
		logic [31:0]                accu;
	} psch_regs_s;
endpackage

// >>> core/psch_top.sv
// Command handler: receives nine-byte frames, keeps working copies of
// axis and global parameters, moves them to and from nonvolatile memory.
// Assumes a nonvolatile port that answers reads with NV_RVALID_IN and
// accepts writes when NV_READY_IN is high.
`include "psch_defs.svh"
module psch_top (
	input  wire logic        MCLK_IN,         // 50 MHz clock
	input  wire logic        RST_B_IN,        // Async reset, active low
	input  wire logic        RX_VALID_IN,     // Frame byte strobe
	input  wire logic [7:0]  RX_BYTE_IN,      // Frame byte
	input  wire logic        USER_AUTOLOAD_IN,// Restore user vars at boot
	input  wire logic        NV_READY_IN,     // Nonvolatile idle
	input  wire logic        NV_RVALID_IN,    // Nonvolatile read data valid
	input  wire logic [31:0] NV_RDATA_IN,     // Nonvolatile read data
	output logic             NV_WE_OUT,       // Nonvolatile write pulse
	output logic             NV_RE_OUT,       // Nonvolatile read pulse
	output logic [`PSCH_ADDR_W-1:0] NV_ADDR_OUT, // Nonvolatile address
	output logic [31:0]      NV_WDATA_OUT,    // Nonvolatile write data
	output logic             BUSY_OUT,        // Frame not accepted now
	output logic             RSP_VALID_OUT,   // Reply pulse
	output logic [7:0]       RSP_STATUS_OUT,  // Reply status
	output logic [7:0]       RSP_INSTR_OUT,   // Reply instruction echo
	output logic [31:0]      RSP_VALUE_OUT,   // Reply value
	output logic [31:0]      ACCU_OUT         // Accumulator
);
	psch_pkg::psch_regs_s r;
	psch_pkg::psch_regs_s next_r;
	logic [31:0]             mem_rdata;
	logic                    mem_we;
	logic [`PSCH_ADDR_W-1:0] mem_waddr;
	logic [31:0]             mem_wdata;

	////////////////////////////////////////////////////////////////////////
	// Bank to storage area; unknown banks fall to axis, callers gate with bank_ok
	function automatic logic [1:0] area_of(input logic [7:0] bank);
		case (bank)
			`PSCH_BANK_SETTINGS: area_of = `PSCH_AREA_SET;
			`PSCH_BANK_USER:     area_of = `PSCH_AREA_USER;
			`PSCH_BANK_IRQ:      area_of = `PSCH_AREA_IRQ;
			default:             area_of = `PSCH_AREA_AXIS;
		endcase
	endfunction

	function automatic logic bank_ok(input logic [7:0] bank);
		bank_ok = (bank == `PSCH_BANK_SETTINGS) || (bank == `PSCH_BANK_USER) ||
			(bank == `PSCH_BANK_IRQ);
	endfunction

	// Same address in working memory and nonvolatile memory
	function automatic logic [`PSCH_ADDR_W-1:0] addr_of(input logic [1:0] area, input logic [7:0] ptype);
		addr_of = {area, ptype};
	endfunction

	psch_mem u_mem (
		.clk_in    (MCLK_IN),
		.we_in     (mem_we),
		.waddr_in  (mem_waddr),
		.wdata_in  (mem_wdata),
		.raddr_in  (next_r.nv_addr),
		.rdata_out (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r           = r;
		next_r.nv_we     = 1'b0;
		next_r.nv_re     = 1'b0;
		next_r.rsp_valid = 1'b0;
		mem_we           = 1'b0;
		mem_waddr        = r.nv_addr;
		mem_wdata        = NV_RDATA_IN;
		case (r.state)
			psch_pkg::PSCH_BOOT: begin
				// Axis area always, user area only when configured
				if (r.boot_addr[`PSCH_ADDR_W-1 -: 2] == `PSCH_AREA_USER && !USER_AUTOLOAD_IN) begin
					next_r.boot_addr = {`PSCH_AREA_IRQ, 8'h00};
				end else if (r.boot_addr[`PSCH_ADDR_W-1 -: 2] == `PSCH_AREA_IRQ) begin
					next_r.state = psch_pkg::PSCH_IDLE;
					next_r.busy  = 1'b0;
				end else if (NV_READY_IN) begin
					next_r.nv_addr = r.boot_addr;
					next_r.nv_re   = 1'b1;
					next_r.state   = psch_pkg::PSCH_BOOTW;
				end
			end
			psch_pkg::PSCH_BOOTW: begin
				if (NV_RVALID_IN) begin
					mem_we           = 1'b1;
					next_r.boot_addr = r.boot_addr + 1'b1;
					if (r.boot_addr[7:0] == 8'hff && r.boot_addr[`PSCH_ADDR_W-1 -: 2] == `PSCH_AREA_AXIS) begin
						next_r.boot_addr = {`PSCH_AREA_USER, 8'h00};
					end
					next_r.state = psch_pkg::PSCH_BOOT;
				end
			end
			psch_pkg::PSCH_IDLE, psch_pkg::PSCH_RECV: begin
				if (RX_VALID_IN) begin
					next_r.sum = r.sum + RX_BYTE_IN;
					next_r.idx = r.idx + 1'b1;
					next_r.state = psch_pkg::PSCH_RECV;
					if (r.idx != `PSCH_FRAME_LAST) begin
						next_r.frm = {r.frm[55:0], RX_BYTE_IN};
					end else begin
						next_r.idx   = 4'h0;
						next_r.sum   = 8'h00;
						next_r.busy  = 1'b1;
						next_r.state = psch_pkg::PSCH_EXEC;
						next_r.rsp.instr  = r.frm.instr;
						next_r.rsp.value  = 32'h0;
						next_r.rsp.status = `PSCH_ST_OK;
						if (r.sum != RX_BYTE_IN) begin
							next_r.rsp.status = `PSCH_ST_BAD_SUM;
							next_r.state      = psch_pkg::PSCH_REPLY;
						end
					end
				end
			end
			psch_pkg::PSCH_EXEC: begin
				next_r.state   = psch_pkg::PSCH_REPLY;
				next_r.nv_addr = addr_of(area_of(r.frm.bank), r.frm.ptype);
				case (r.frm.instr)
					`PSCH_OP_STORE_AXIS, `PSCH_OP_RESTORE_AXIS: begin
						next_r.nv_addr = addr_of(`PSCH_AREA_AXIS, r.frm.ptype);
						next_r.state   = (r.frm.instr == `PSCH_OP_STORE_AXIS) ?
							psch_pkg::PSCH_NVW : psch_pkg::PSCH_NVR;
					end
					`PSCH_OP_WRITE_GLOBAL: begin
						if (bank_ok(r.frm.bank)) begin
							mem_we    = 1'b1;
							mem_waddr = addr_of(area_of(r.frm.bank), r.frm.ptype);
							mem_wdata = r.frm.value;
							if (r.frm.bank == `PSCH_BANK_SETTINGS) begin
								next_r.state = psch_pkg::PSCH_NVW;
							end
						end else begin
							next_r.rsp.status = `PSCH_ST_BAD_VALUE;
						end
					end
					`PSCH_OP_READ_GLOBAL: begin
						if (!bank_ok(r.frm.bank)) begin
							next_r.rsp.status = `PSCH_ST_BAD_VALUE;
						end else begin
							next_r.state = psch_pkg::PSCH_NVR;
						end
					end
					`PSCH_OP_PERSIST_GLOB: begin
						if (r.frm.bank == `PSCH_BANK_USER) begin
							next_r.state = psch_pkg::PSCH_NVW;
						end else begin
							next_r.rsp.status = `PSCH_ST_BAD_VALUE;
						end
					end
					default: next_r.rsp.status = `PSCH_ST_BAD_CMD;
				endcase
			end
			psch_pkg::PSCH_NVW: begin
				// Working copy read lands this cycle; hold until storage is idle
				if (NV_READY_IN) begin
					next_r.nv_we    = 1'b1;
					next_r.nv_wdata = (r.frm.instr == `PSCH_OP_WRITE_GLOBAL) ? r.frm.value : mem_rdata;
					next_r.state    = psch_pkg::PSCH_REPLY;
				end
			end
			psch_pkg::PSCH_NVR: begin
				if (r.frm.instr == `PSCH_OP_READ_GLOBAL) begin
					next_r.accu      = mem_rdata;
					next_r.rsp.value = mem_rdata;
					next_r.state     = psch_pkg::PSCH_REPLY;
				end else if (!r.nv_pend) begin
					// One request only; a slow store must not be asked again
					if (NV_READY_IN) begin
						next_r.nv_re   = 1'b1;
						next_r.nv_pend = 1'b1;
					end
				end else if (NV_RVALID_IN) begin
					mem_we         = 1'b1;
					next_r.nv_pend = 1'b0;
					next_r.state   = psch_pkg::PSCH_REPLY;
				end
			end
			psch_pkg::PSCH_REPLY: begin
				next_r.rsp_valid = 1'b1;
				next_r.busy      = 1'b0;
				next_r.state     = psch_pkg::PSCH_IDLE;
			end
			default: next_r.state = psch_pkg::PSCH_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			r       <= '0;
			r.state <= psch_pkg::PSCH_BOOT;
			r.busy  <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign NV_WE_OUT      = r.nv_we;
	assign NV_RE_OUT      = r.nv_re;
	assign NV_ADDR_OUT    = r.nv_addr;
	assign NV_WDATA_OUT   = r.nv_wdata;
	assign BUSY_OUT       = r.busy;
	assign RSP_VALID_OUT  = r.rsp_valid;
	assign RSP_STATUS_OUT = r.rsp.status;
	assign RSP_INSTR_OUT  = r.rsp.instr;
	assign RSP_VALUE_OUT  = r.rsp.value;
	assign ACCU_OUT       = r.accu;

	////////////////////////////////////////////////////////////////////////
	sequence read_reply_s;
		RSP_VALID_OUT && RSP_STATUS_OUT == `PSCH_ST_OK;
	endsequence

	read_reply_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(r.state == psch_pkg::PSCH_NVR && r.frm.instr == `PSCH_OP_READ_GLOBAL)
		|=> ##1 (read_reply_s and (RSP_VALUE_OUT == ACCU_OUT)))
		else $error("read reply wrong");
	accu_load_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		$changed(ACCU_OUT) |-> $past(r.frm.instr) == `PSCH_OP_READ_GLOBAL)
		else $error("accumulator changed without read");
	bank0_persist_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(r.state == psch_pkg::PSCH_EXEC && r.frm.instr == `PSCH_OP_WRITE_GLOBAL &&
		r.frm.bank == `PSCH_BANK_SETTINGS) |=> r.state == psch_pkg::PSCH_NVW)
		else $error("bank 0 write not persisted");
	bad_sum_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(RX_VALID_IN && r.idx == `PSCH_FRAME_LAST && r.sum != RX_BYTE_IN &&
		(r.state == psch_pkg::PSCH_RECV)) |=> ##1 RSP_VALID_OUT && RSP_STATUS_OUT == `PSCH_ST_BAD_SUM)
		else $error("bad checksum not reported");
	store_axis_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(r.state == psch_pkg::PSCH_EXEC && r.frm.instr == `PSCH_OP_STORE_AXIS)
		|=> r.state == psch_pkg::PSCH_NVW && NV_ADDR_OUT[`PSCH_ADDR_W-1 -: 2] == `PSCH_AREA_AXIS)
		else $error("store axis not started");
	user_store_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(NV_WE_OUT && r.frm.instr == `PSCH_OP_PERSIST_GLOB) |->
		NV_ADDR_OUT[`PSCH_ADDR_W-1 -: 2] == `PSCH_AREA_USER)
		else $error("persist outside user bank");
	bad_bank_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(r.state == psch_pkg::PSCH_EXEC && r.frm.instr == `PSCH_OP_WRITE_GLOBAL && !bank_ok(r.frm.bank))
		|=> ##1 RSP_VALID_OUT && RSP_STATUS_OUT == `PSCH_ST_BAD_VALUE)
		else $error("bad bank accepted");
	boot_busy_a: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(r.state == psch_pkg::PSCH_BOOT || r.state == psch_pkg::PSCH_BOOTW) |-> BUSY_OUT && !RSP_VALID_OUT)
		else $error("busy low during boot load");
endmodule

// >>> sim/psch_nv_model.sv
// Behavioural nonvolatile store beside the command handler.
// Assumes one clock; contents survive reset, as a real store would.
module psch_nv_model (
	input  wire logic        clk_in,     // System clock
	input  wire logic        rst_b_in,   // Reset, active low
	input  wire logic        slow_in,    // Stretch answers
	input  wire logic        we_in,      // Write pulse
	input  wire logic        re_in,      // Read pulse
	input  wire logic [9:0]  addr_in,    // Word address
	input  wire logic [31:0] wdata_in,   // Write data
	output logic             ready_out,  // Idle
	output logic             rvalid_out, // Read data valid
	output logic [31:0]      rdata_out   // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:1023];
	logic [9:0]  raddr;
	logic [2:0]  rcnt;
	logic [2:0]  wcnt;
	////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 32'ha5000000 | 32'(i);
	end
	assign ready_out = (wcnt == 3'h0);
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rcnt       <= 3'h0;
			wcnt       <= 3'h0;
			rvalid_out <= 1'b0;
			rdata_out  <= 32'h0;
		end else begin
			rvalid_out <= 1'b0;
			// Data is not held once valid has gone
			rdata_out  <= ~rdata_out;
			if (we_in) begin
				mem[addr_in] <= wdata_in;
				wcnt         <= slow_in ? 3'h4 : 3'h1;
			end else if (wcnt != 3'h0) begin
				wcnt <= wcnt - 3'h1;
			end
			if (re_in) begin
				raddr <= addr_in;
				rcnt  <= slow_in ? 3'h3 : 3'h1;
			end else if (rcnt == 3'h1) begin
				rvalid_out <= 1'b1;
				rdata_out  <= mem[raddr];
				rcnt       <= 3'h0;
			end else if (rcnt != 3'h0) begin
				rcnt <= rcnt - 3'h1;
			end
		end
	end
endmodule

// >>> sim/test_psch_top.sv
// Self-checking bench of the command handler with a nonvolatile model.
// Assumes the model's preset word at address a is a5000000 | a.
module test_psch_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst_b, rx_valid, autoload, slow, nv_we, nv_re, nv_ready, nv_rvalid, busy, rsp_valid;
	logic [7:0]  rx_byte, rsp_status, rsp_instr, st;
	logic [9:0]  nv_addr, wr_addr;
	logic [31:0] nv_wdata, nv_rdata, rsp_value, accu, wr_data, val;
	int          n_errors, num_checks, n_rd, n_wr, w0;
	logic [7:0]  bk_list [3] = '{8'h00, 8'h02, 8'h03};
	////////////////////////////////////////////////////////////////
	psch_top i_dut (.MCLK_IN(mclk), .RST_B_IN(rst_b), .RX_VALID_IN(rx_valid), .RX_BYTE_IN(rx_byte),
		.USER_AUTOLOAD_IN(autoload), .NV_READY_IN(nv_ready), .NV_RVALID_IN(nv_rvalid), .NV_RDATA_IN(nv_rdata),
		.NV_WE_OUT(nv_we), .NV_RE_OUT(nv_re), .NV_ADDR_OUT(nv_addr), .NV_WDATA_OUT(nv_wdata), .BUSY_OUT(busy),
		.RSP_VALID_OUT(rsp_valid), .RSP_STATUS_OUT(rsp_status), .RSP_INSTR_OUT(rsp_instr),
		.RSP_VALUE_OUT(rsp_value), .ACCU_OUT(accu));
	psch_nv_model i_nv (.clk_in(mclk), .rst_b_in(rst_b), .slow_in(slow), .we_in(nv_we), .re_in(nv_re),
		.addr_in(nv_addr), .wdata_in(nv_wdata), .ready_out(nv_ready), .rvalid_out(nv_rvalid), .rdata_out(nv_rdata));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (nv_re === 1'b1) n_rd++;
		if (nv_we === 1'b1) begin
			n_wr++;
			wr_addr = nv_addr;
			wr_data = nv_wdata;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input bit ok, input string msg);
		num_checks++;
		if (!ok) begin
			n_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge mclk);
		if (busy !== 1'b0) begin
			check(0, "busy stuck");
			end_of_test();
		end
	endtask
	// Sends one frame; adj spoils the checksum when nonzero
	task automatic send(input logic [7:0] ins, pt, bk, input logic [31:0] v, input logic [7:0] adj);
		logic [7:0] b [0:8];
		b = '{8'h01, ins, pt, bk, v[31:24], v[23:16], v[15:8], v[7:0], adj};
		for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
		wait_idle();
		for (int i = 0; i < 9; i++) begin
			@(posedge mclk);
			rx_valid <= 1'b1;
			rx_byte  <= b[i];
		end
		@(posedge mclk);
		rx_valid <= 1'b0;
		for (int k = 0; k < 200 && rsp_valid !== 1'b1; k++) @(negedge mclk);
		if (rsp_valid !== 1'b1) begin
			check(0, "no reply");
			end_of_test();
		end
		st  = rsp_status;
		val = rsp_value;
		check(rsp_instr === ins, "instruction echo");
	endtask
	task automatic boot(input logic al);
		@(posedge mclk);
		rst_b    <= 1'b0;
		autoload <= al;
		repeat (3) @(posedge mclk);
		n_rd = 0;
		check(busy === 1'b1, "busy in reset");
		rst_b <= 1'b1;
		wait_idle();
		check(n_rd == (al ? 512 : 256), "boot load count");
		$display("boot test done");
	endtask
	task automatic t_user_boot();
		send(8'h0a, 8'h10, 8'h02, 32'h0, 8'h00);
		check(st === 8'h64 && val === 32'ha5000210, "user var restored");
		$display("user boot test done");
	endtask
	task automatic t_global();
		logic [7:0] bk;
		logic [7:0] pt;
		foreach (bk_list[j]) begin
			bk = bk_list[j];
			pt = 8'h42 ^ bk;
			w0 = n_wr;
			send(8'h09, pt, bk, 32'h12340000 | 32'(bk), 8'h00);
			check(st === 8'h64, "write status");
			check(n_wr == w0 + (bk == 8'h00), "auto persist count");
			if (bk == 8'h00) check(wr_addr === {2'h1, pt} && wr_data === 32'h12340000, "setting persisted");
			send(8'h0a, pt, bk, 32'h0, 8'h00);
			check(st === 8'h64 && val === (32'h12340000 | 32'(bk)), "read reply");
			check(accu === (32'h12340000 | 32'(bk)), "accumulator");
			w0 = n_wr;
			send(8'h0b, pt, bk, 32'h0, 8'h00);
			if (bk == 8'h02) check(st === 8'h64 && wr_addr === {2'h2, pt} && wr_data === 32'h12340002, "store user");
			else check(st === 8'h04 && n_wr == w0, "store refused");
		end
		$display("global test done");
	endtask
	task automatic t_axis();
		slow <= 1'b1;
		i_nv.mem[7] = 32'h0bad0007;
		send(8'h07, 8'h07, 8'h00, 32'h0, 8'h00);
		check(st === 8'h64 && i_nv.mem[7] === 32'ha5000007, "store axis");
		i_nv.mem[7] = 32'h11112222;
		send(8'h08, 8'h07, 8'h00, 32'h0, 8'h00);
		check(st === 8'h64, "restore status");
		i_nv.mem[7] = 32'h0;
		send(8'h07, 8'h07, 8'h00, 32'h0, 8'h00);
		check(i_nv.mem[7] === 32'h11112222, "restored copy");
		slow <= 1'b0;
		$display("axis test done");
	endtask
	task automatic t_refuse();
		w0 = n_wr;
		send(8'h09, 8'h05, 8'h00, 32'h77, 8'h01);
		check(st === 8'h01, "bad sum");
		send(8'h05, 8'h05, 8'h00, 32'h77, 8'h00);
		check(st === 8'h02, "bad instruction");
		send(8'h09, 8'h05, 8'h01, 32'h77, 8'h00);
		check(st === 8'h04 && n_wr == w0, "bad bank");
		$display("refuse test done");
	endtask
	initial begin
		rst_b    = 1'b0;
		rx_valid = 1'b0;
		rx_byte  = 8'h00;
		autoload = 1'b1;
		slow     = 1'b0;
		boot(1'b1);
		t_user_boot();
		t_global();
		t_axis();
		t_refuse();
		boot(1'b0);
		end_of_test();
	end
endmodule
